// File: include/boot_rom_pkg.sv
// Package: constants and carriers for the boot memory decoder
package boot_rom_pkg;

   // ==========================================
   // Address windows
   localparam logic [31:0] ROM_HIGH_BASE   = 32'hff800000;
   localparam logic [31:0] ROM_HIGH_LAST   = 32'hffbfffff;
   localparam logic [31:0] ROM_LOW_LAST    = 32'h003fffff;
   localparam logic [31:0] EPROM_LOW_LAST  = 32'h000fffff;
   localparam logic [31:0] EPROM_HIGH_LAST = 32'hff8fffff;
   localparam logic [31:0] FLASH_MIX_FIRST = 32'h00200000;
   localparam logic [31:0] FLASH_MIX_LAST  = 32'h003fffff;
   localparam int          ROM_SPAN_BITS   = 22;
   localparam int          HALF_BIT        = 21;
   localparam int          EPROM_BITS      = 20;

   // ==========================================
   // Register offsets (word addresses on the plain port)
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_STATUS      = 4'h1;
   localparam logic [3:0]  REG_RESET_CAUSE = 4'h2;

   // ==========================================
   // Control register fields
   localparam int          CTRL_HALF_POS   = 2;
   localparam int          CTRL_WP_POS     = 1;
   localparam int          CTRL_ALIAS_POS  = 20;
   localparam int          CTRL_SWAP_POS   = 21;
   localparam int          CTRL_AT_POS     = 24;
   localparam int          CTRL_DEC_POS    = 28;
   localparam logic [3:0]  ACCESS_TIME_RST = 4'h3;
   localparam logic        WP_RST          = 1'b1;
   localparam logic        HALF_RST        = 1'b0;
   localparam logic        ALIAS_RST       = 1'b1;
   localparam logic        SWAP_RST        = 1'b0;
   localparam logic        DEC_EN_RST      = 1'b1;

   // ==========================================
   // Reset source codes
   localparam int          NUM_RST_SRC     = 5;
   localparam int          SRC_WDOG        = 0;
   localparam int          SRC_PANEL       = 1;
   localparam int          SRC_BOARD       = 2;
   localparam int          SRC_SYSRST      = 3;
   localparam int          SRC_POWER       = 4;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
   } bus_req_t;

   typedef struct packed {
      logic        flash_sel;
      logic        eprom_sel;
      logic [3:0]  lanes;
      logic [21:0] dev_addr;
      logic        write_err;
      logic        hit;
   } rom_sel_t;

   typedef enum logic [2:0] {
      CYC_IDLE = 3'b001,
      CYC_WAIT = 3'b010,
      CYC_DONE = 3'b100
   } cyc_state_t;

endpackage

// File: logic/boot_rom_flash_decoder.sv
// Boot memory decoder: Flash/EPROM windows, boot alias, write protect and local reset
`timescale 1ns/1ns
module boot_rom_flash_decoder
   import boot_rom_pkg::*;
#(
   parameter int SYNC_STAGES = 3
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Board pins and reset sources
   input  wire logic        rom_config_jumper,
   input  wire logic        watchdog_expired,
   input  wire logic        panel_reset_n,
   input  wire logic        sys_ctrl_enabled,
   input  wire logic        board_reset_bit,
   input  wire logic        sysreset_n,
   input  wire logic        power_up_reset,
   // Local bus request
   input  wire bus_req_t    bus_req,
   input  wire logic        remote_req,
   input  wire logic        dram_hit,
   input  wire logic        sram_hit,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Decode results
   output rom_sel_t         rom_sel,
   output logic             rom_ack,
   output logic             dram_sel,
   output logic             sram_sel,
   output logic             remote_ignored,
   output logic             local_reset,
   output logic [3:0]       access_time
);

   generate
      if (SYNC_STAGES != 3) begin : g_bad_sync
         $error("SYNC_STAGES must be 3");
      end
   endgenerate

   // ==========================================
   // Pin synchronisers
   localparam int              NPIN    = 6;
   localparam logic [NPIN-1:0] PIN_RST = 6'b100000;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] pin_q;
   assign pin_raw = {rom_config_jumper, watchdog_expired, ~panel_reset_n,
                     board_reset_bit, ~sysreset_n, power_up_reset};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1_q <= PIN_RST;
         s2_q <= PIN_RST;
         s3_q <= PIN_RST;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               pin_q[gi] <= PIN_RST[gi];
            end else if (s2_q[gi] == s3_q[gi]) begin
               pin_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   logic jumper_high;
   assign jumper_high = pin_q[5];

   // ==========================================
   // Local reset
   logic [NUM_RST_SRC-1:0] src;
   logic                   local_reset_d;
   logic                   local_reset_q;
   assign src[SRC_WDOG]   = pin_q[4];
   assign src[SRC_PANEL]  = pin_q[3] & ~sys_ctrl_enabled;
   assign src[SRC_BOARD]  = pin_q[2];
   assign src[SRC_SYSRST] = pin_q[1];
   assign src[SRC_POWER]  = pin_q[0];
   assign local_reset_d   = |src;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         local_reset_q <= 1'b1;
      end else begin
         local_reset_q <= local_reset_d;
      end
   end

   // ==========================================
   // Control and cause registers
   logic [3:0]             access_time_q;
   logic                   wp_q;
   logic                   half_q;
   logic                   alias_q;
   logic                   swap_q;
   logic                   dec_en_q;
   logic [NUM_RST_SRC-1:0] cause_q;
   logic                   ctrl_wr;
   assign ctrl_wr = reg_wr && reg_addr == REG_CTRL;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         access_time_q <= ACCESS_TIME_RST;
      end else if (local_reset_q) begin
         access_time_q <= ACCESS_TIME_RST;
      end else if (ctrl_wr) begin
         access_time_q <= reg_wdata[CTRL_AT_POS +: 4];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_q <= WP_RST;
      end else if (local_reset_q) begin
         wp_q <= WP_RST;
      end else if (ctrl_wr) begin
         wp_q <= reg_wdata[CTRL_WP_POS];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         half_q <= HALF_RST;
      end else if (local_reset_q) begin
         half_q <= HALF_RST;
      end else if (ctrl_wr) begin
         half_q <= reg_wdata[CTRL_HALF_POS];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         alias_q <= ALIAS_RST;
      end else if (local_reset_q) begin
         alias_q <= ALIAS_RST;
      end else if (ctrl_wr) begin
         alias_q <= reg_wdata[CTRL_ALIAS_POS];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         swap_q <= SWAP_RST;
      end else if (local_reset_q) begin
         swap_q <= SWAP_RST;
      end else if (ctrl_wr) begin
         swap_q <= reg_wdata[CTRL_SWAP_POS];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dec_en_q <= DEC_EN_RST;
      end else if (local_reset_q) begin
         dec_en_q <= DEC_EN_RST;
      end else if (ctrl_wr) begin
         dec_en_q <= reg_wdata[CTRL_DEC_POS];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cause_q <= '0;
      end else if (reg_wr && reg_addr == REG_RESET_CAUSE) begin
         cause_q <= (cause_q & ~reg_wdata[NUM_RST_SRC-1:0]) | src;
      end else begin
         cause_q <= cause_q | src;
      end
   end

   // ==========================================
   // Address decode
   rom_sel_t   sel_d;
   logic [31:0] a;
   logic       low_win;
   logic       high_win;
   logic       in_low;
   logic       in_high;
   logic       eprom_area;
   logic       flash_part;
   logic [3:0] lanes;

   always_comb begin
      a = bus_req.addr;
      case (bus_req.size)
         2'd0: lanes = 4'b1000 >> a[1:0];
         2'd1: lanes = a[1] ? 4'b0011 : 4'b1100;
         default: lanes = 4'b1111;
      endcase
   end

   always_comb begin
      high_win   = a >= ROM_HIGH_BASE && a <= ROM_HIGH_LAST;
      low_win    = alias_q && a <= ROM_LOW_LAST;
      in_high    = dec_en_q && high_win;
      in_low     = low_win;
      eprom_area = ~jumper_high && (a[HALF_BIT] == swap_q);
      flash_part = jumper_high || ~eprom_area;
      sel_d          = '0;
      sel_d.lanes    = lanes;
      sel_d.hit      = bus_req.valid && !local_reset_q && (in_low || in_high);
      if (sel_d.hit) begin
         if (flash_part) begin
            sel_d.flash_sel = 1'b1;
            sel_d.dev_addr  = jumper_high ? a[ROM_SPAN_BITS-1:0]
                            : {half_q, a[HALF_BIT-1:0]};
            sel_d.write_err = bus_req.write && wp_q;
         end else begin
            sel_d.eprom_sel = 1'b1;
            sel_d.dev_addr  = {2'b00, a[EPROM_BITS-1:0]};
            sel_d.write_err = bus_req.write;
         end
         if (sel_d.write_err) begin
            sel_d.flash_sel = 1'b0;
            sel_d.eprom_sel = 1'b0;
         end
      end
   end

   // ==========================================
   // Cycle timing
   cyc_state_t st_q;
   logic [3:0] wait_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= CYC_IDLE;
      end else begin
         case (st_q)
            // Request still held in the ack cycle: not a new access
            CYC_IDLE: begin
               if (sel_d.hit && !local_reset_q && !rom_ack) begin
                  st_q <= CYC_WAIT;
               end
            end
            CYC_WAIT: begin
               if (wait_q == 4'h0) begin
                  st_q <= CYC_DONE;
               end
            end
            CYC_DONE: st_q <= CYC_IDLE;
            default:  st_q <= CYC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_q <= '0;
      end else if (st_q == CYC_IDLE) begin
         wait_q <= access_time_q;
      end else if (st_q == CYC_WAIT && wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end
   end

   // ==========================================
   // Registered outputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rom_sel <= '0;
         rom_ack <= 1'b0;
      end else begin
         rom_sel <= sel_d;
         rom_ack <= (st_q == CYC_DONE);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dram_sel <= 1'b0;
         sram_sel <= 1'b0;
      end else begin
         dram_sel <= dram_hit && !(sel_d.hit && in_low);
         sram_sel <= sram_hit && !(sel_d.hit && in_low);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         remote_ignored <= 1'b0;
         local_reset    <= 1'b1;
      end else begin
         remote_ignored <= remote_req && local_reset_q;
         local_reset    <= local_reset_q;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         access_time <= ACCESS_TIME_RST;
      end else begin
         access_time <= access_time_q;
      end
   end

   // ==========================================
   // Register read port
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: begin
               reg_rdata <= '0;
               reg_rdata[CTRL_AT_POS +: 4] <= access_time_q;
               reg_rdata[CTRL_WP_POS]      <= wp_q;
               reg_rdata[CTRL_HALF_POS]    <= half_q;
               reg_rdata[CTRL_ALIAS_POS]   <= alias_q;
               reg_rdata[CTRL_SWAP_POS]    <= swap_q;
               reg_rdata[CTRL_DEC_POS]     <= dec_en_q;
            end
            REG_STATUS:      reg_rdata <= {29'h0, local_reset_q, jumper_high, st_q != CYC_IDLE};
            REG_RESET_CAUSE: reg_rdata <= {27'h0, cause_q};
            default:         reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// File: testbench/rom_decoder_checker_assertions.sv
// Port checker for the boot memory decoder
`timescale 1ns/1ns
module rom_decoder_checker
   import boot_rom_pkg::*;
#(
   parameter int SYNC_STAGES = 3
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // Watched ports
   input wire bus_req_t    bus_req,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire rom_sel_t    rom_sel,
   input wire logic        rom_ack,
   input wire logic        dram_sel,
   input wire logic        local_reset,
   input wire logic [3:0]  access_time,
   input wire logic        watchdog_expired,
   input wire logic        sysreset_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ====
   // Checks
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside slot");
   a_hit_window: assert property (rom_sel.hit |-> $past(bus_req.addr) <= ROM_LOW_LAST ||
      ($past(bus_req.addr) >= ROM_HIGH_BASE && $past(bus_req.addr) <= ROM_HIGH_LAST))
      else $error("hit outside windows");
   a_err_nosel: assert property (rom_sel.write_err |-> !rom_sel.flash_sel && !rom_sel.eprom_sel)
      else $error("blocked write selected");
   a_eprom_read: assert property (rom_sel.eprom_sel |-> !$past(bus_req.write))
      else $error("eprom write selected");
   a_alias_wins: assert property ((rom_sel.flash_sel || rom_sel.eprom_sel) &&
      $past(bus_req.addr) <= ROM_LOW_LAST |-> !dram_sel)
      else $error("dram beside low rom");
   a_ack_pulse: assert property (rom_ack |=> !rom_ack)
      else $error("ack too long");
   a_ack_time: assert property ($rose(rom_sel.hit) && !rom_sel.write_err &&
      access_time == 4'h3 |-> ##5 rom_ack)
      else $error("ack late or early");
   a_reset_src: assert property (watchdog_expired || !sysreset_n |-> ##[1:8] local_reset)
      else $error("local reset missing");
   a_lr_nohit: assert property (local_reset && $past(local_reset) |-> !$past(rom_sel.hit))
      else $error("hit in local reset");
endmodule
bind boot_rom_flash_decoder rom_decoder_checker #(.SYNC_STAGES(SYNC_STAGES)) i_chk (
   .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .rom_sel(rom_sel), .rom_ack(rom_ack), .dram_sel(dram_sel), .local_reset(local_reset),
   .access_time(access_time), .watchdog_expired(watchdog_expired), .sysreset_n(sysreset_n));

// File: testbench/local_master.sv
// Local bus master model
`timescale 1ns/1ns
module local_master
   import boot_rom_pkg::*;
(
   // Clock
   input  wire logic     clk_sys,
   // Decoder answers
   input  wire rom_sel_t rom_sel,
   input  wire logic     rom_ack,
   input  wire logic     dram_sel,
   // Request
   output bus_req_t      bus_req
);
   rom_sel_t seen;
   logic     dseen;
   int       n_cyc;
   initial bus_req = '{1'b0, 1'b0, 2'h0, 32'hffffffff};
   // Sole master, one cycle at a time
   task automatic access(input logic [31:0] a, input logic w, input logic [1:0] s);
      @(posedge clk_sys);
      bus_req <= '{1'b1, w, s, a};
      n_cyc = 0;
      for (int i = 1; i <= 40 && n_cyc == 0; i++) begin
         @(posedge clk_sys);
         if (i == 2) begin
            seen = rom_sel;
            dseen = dram_sel;
         end
         if (rom_ack === 1'b1) n_cyc = i - 1;
      end
      bus_req <= '{1'b0, 1'b0, 2'h0, ~a};
   endtask
endmodule

// File: testbench/testbench.sv
// Testbench for the boot memory decoder
`timescale 1ns/1ns
module testbench;
   import boot_rom_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        jmp = 1'b0;
   logic        sc_en = 1'b1;
   logic        remote = 1'b0;
   logic        dhit = 1'b0;
   logic [4:0]  srcs = 5'h0;
   logic [3:0]  ra = 4'h0;
   logic [31:0] wd = 32'h0;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic [31:0] rdat;
   bus_req_t    req;
   rom_sel_t    sel;
   logic        ack;
   logic        dsel;
   logic        ssel;
   logic        rig;
   logic        lr;
   logic [3:0]  at;
   int          miscompares = 0;
   int          n_tests = 0;
   always #10 clk_sys = ~clk_sys;
   boot_rom_flash_decoder i_dut (.clk_sys(clk_sys), .rst(rst), .rom_config_jumper(jmp),
      .watchdog_expired(srcs[0]), .panel_reset_n(~srcs[1]), .sys_ctrl_enabled(sc_en),
      .board_reset_bit(srcs[2]), .sysreset_n(~srcs[3]), .power_up_reset(srcs[4]), .bus_req(req),
      .remote_req(remote), .dram_hit(dhit), .sram_hit(dhit), .reg_addr(ra), .reg_wdata(wd),
      .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .rom_sel(sel), .rom_ack(ack),
      .dram_sel(dsel), .sram_sel(ssel), .remote_ignored(rig), .local_reset(lr), .access_time(at));
   local_master i_cpu (.clk_sys(clk_sys), .rom_sel(sel), .rom_ack(ack), .dram_sel(dsel), .bus_req(req));
   // ====
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      @(posedge clk_sys);
      chk("reg_rdata", e, rdat);
   endtask
   task automatic wlr(input logic v);
      for (int n = 0; n < 30 && lr !== v; n++) @(posedge clk_sys);
      chk("local_reset", {31'h0, v}, {31'h0, lr});
      if (lr !== v) test_done();
   endtask
   task automatic dec(input logic [31:0] a, input logic w, input logic [2:0] e);
      i_cpu.access(a, w, 2'h2);
      chk("decode", {29'h0, e}, {29'h0, i_cpu.seen.flash_sel, i_cpu.seen.eprom_sel, i_cpu.seen.write_err});
      chk("rom_ack", {31'h0, e != 3'b000}, {31'h0, i_cpu.n_cyc != 0});
      if (e != 3'b000 && i_cpu.n_cyc == 0) test_done();
   endtask
   task automatic pulse(input int i);
      remote <= (i == 0);
      srcs <= 5'h1 << i;
      wlr(1'b1);
      @(posedge clk_sys);
      chk("remote_ignored", {31'h0, remote}, {31'h0, rig});
      dec(32'h10, 1'b0, 3'b000);
      srcs <= 5'h0;
      wlr(1'b0);
      rd(REG_RESET_CAUSE, 32'h1 << i);
      wr(REG_RESET_CAUSE, 32'h1f);
      rd(REG_CTRL, 32'h13100002);
      dec(32'h10, 1'b0, 3'b100);
   endtask
   // ====
   // Sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      wlr(1'b0);
      rd(REG_CTRL, 32'h13100002);
      rd(REG_STATUS, 32'h0);
      rd(4'h9, 32'h0);
      dec(32'h10, 1'b0, 3'b010);
      dec(32'h100010, 1'b0, 3'b010);
      dec(32'h0, 1'b1, 3'b001);
      dec(32'hff800000, 1'b0, 3'b010);
      dec(32'h200004, 1'b1, 3'b001);
      dec(32'h200004, 1'b0, 3'b100);
      chk("dev_addr", 32'h4, {10'h0, i_cpu.seen.dev_addr});
      wr(REG_CTRL, 32'h13100004);
      dec(32'h200004, 1'b1, 3'b100);
      chk("dev_addr", 32'h200004, {10'h0, i_cpu.seen.dev_addr});
      chk("ack_cycles", 32'h6, i_cpu.n_cyc);
      i_cpu.access(32'h200001, 1'b0, 2'h0);
      chk("lanes", 32'h4, {28'h0, i_cpu.seen.lanes});
      i_cpu.access(32'h200002, 1'b0, 2'h1);
      chk("lanes", 32'h3, {28'h0, i_cpu.seen.lanes});
      wr(REG_CTRL, 32'h15100004);
      repeat (2) @(posedge clk_sys);
      chk("access_time", 32'h5, {28'h0, at});
      dhit <= 1'b1;
      dec(32'h10, 1'b0, 3'b010);
      chk("ack_cycles", 32'h8, i_cpu.n_cyc);
      chk("dram_sel", 32'h0, {31'h0, i_cpu.dseen});
      wr(REG_CTRL, 32'h15000004);
      dec(32'h10, 1'b0, 3'b000);
      chk("dram_sel", 32'h1, {31'h0, i_cpu.dseen});
      chk("sram_sel", 32'h1, {31'h0, ssel});
      dhit <= 1'b0;
      jmp <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd(REG_STATUS, 32'h2);
      dec(32'hff800010, 1'b0, 3'b100);
      srcs <= 5'h2;
      repeat (12) @(posedge clk_sys);
      chk("local_reset", 32'h0, {31'h0, lr});
      srcs <= 5'h0;
      repeat (6) @(posedge clk_sys);
      sc_en <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < NUM_RST_SRC; i++) pulse(i);
      test_done();
   end
endmodule
